// ==== design/ard_map.svh ====
`ifndef ARD_MAP_SVH
`define ARD_MAP_SVH

// Bus geometry
`define ARD_NUM         16
`define ARD_IDXW        4
`define ARD_AW          32
`define ARD_DW          32
`define ARD_RESPW       2

// Built-in defaults, replaceable through module parameters
`define ARD_DEF_MASTER  4'h0
`define ARD_DEF_SLAVE   4'h0

// Range register reset values: a zero size matches no address
`define ARD_RST_BASE    32'h0000_0000
`define ARD_RST_SIZE    32'h0000_0000

// Arbitration constants: reset index, round-robin pointer step and empty request vector
`define ARD_RST_IDX     4'h0
`define ARD_IDX_ONE     4'h1
`define ARD_NO_REQ      16'h0000

`endif

// ==== design/ard_pkg.sv ====
`include "ard_map.svh"

package ard_pkg;

    typedef logic [`ARD_IDXW-1:0]  ard_idx_type;
    typedef logic [`ARD_NUM-1:0]   ard_vec_type;
    typedef logic [`ARD_AW-1:0]    ard_word_type;
    typedef logic [`ARD_RESPW-1:0] ard_resp_type;

endpackage

// ==== design/ard_arbiter_decoder.sv ====

`include "ard_map.svh"

module ard_arbiter_decoder
    import ard_pkg::*;
#(
    parameter ard_idx_type DEF_MASTER = `ARD_DEF_MASTER,
    parameter ard_idx_type DEF_SLAVE  = `ARD_DEF_SLAVE
) (
    input  wire logic                          core_clk,
    input  wire logic                          reset,
    // Arbitration
    input  wire logic [`ARD_NUM-1:0]           hbusreq,
    input  wire logic [`ARD_NUM-1:0]           hlock,
    output logic      [`ARD_NUM-1:0]           hgrant,
    output logic      [`ARD_IDXW-1:0]          hmaster,
    output logic                               hmastlock,
    // Address phase of the shared bus
    input  wire logic [`ARD_AW-1:0]            haddr,
    // Slave side
    output logic      [`ARD_NUM-1:0]           hsel,
    input  wire logic [`ARD_NUM-1:0]           hreadyoutS,
    input  wire logic [`ARD_NUM*`ARD_RESPW-1:0] hrespS,
    input  wire logic [`ARD_NUM*`ARD_DW-1:0]   hrdataS,
    // Steered response
    output logic                               hready,
    output logic      [`ARD_RESPW-1:0]         hresp,
    output logic      [`ARD_DW-1:0]            hrdata,
    // Map programming port
    input  wire logic                          cfgWrEn,
    input  wire logic [`ARD_IDXW-1:0]          cfgIdx,
    input  wire logic [`ARD_AW-1:0]            cfgBase,
    input  wire logic [`ARD_AW-1:0]            cfgSize,
    // Exported slave map
    output logic      [`ARD_NUM*`ARD_AW-1:0]   mapBase,
    output logic      [`ARD_NUM*`ARD_AW-1:0]   mapSize
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // First requester strictly after ptr, wrapping; ptr itself comes last
    function automatic ard_idx_type rrPick(input ard_vec_type req,
                                           input ard_idx_type ptr);
        ard_idx_type cand;
        ard_idx_type pick;
        logic        found;
        pick  = ptr;
        found = 1'b0;
        cand  = ptr;
        for (int k = 0; k < `ARD_NUM; k++) begin
            cand = cand + `ARD_IDX_ONE;
            if (!found && req[cand]) begin
                pick  = cand;
                found = 1'b1;
            end
        end
        return pick;
    endfunction

    // Half-open window; sum kept one bit wider so the top never wraps
    function automatic logic inRange(input ard_word_type addr,
                                     input ard_word_type base,
                                     input ard_word_type size);
        logic [`ARD_AW:0] top;
        top = {1'b0, base} + {1'b0, size};
        return ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < top);
    endfunction

    function automatic ard_vec_type idxToVec(input ard_idx_type idx);
        ard_vec_type v;
        v      = `ARD_NO_REQ;
        v[idx] = 1'b1;
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Slave range registers

    ard_word_type base_r   [`ARD_NUM];
    ard_word_type size_r   [`ARD_NUM];
    ard_word_type base_nxt [`ARD_NUM];
    ard_word_type size_nxt [`ARD_NUM];

    // Host writes one slot at a time; apart from reset nothing else touches the map
    always_comb begin
        for (int i = 0; i < `ARD_NUM; i++) begin
            base_nxt[i] = base_r[i];
            size_nxt[i] = size_r[i];
        end
        if (cfgWrEn) begin
            base_nxt[cfgIdx] = cfgBase;
            size_nxt[cfgIdx] = cfgSize;
        end
    end

    // Zero size means an empty window, so every access goes to the default slave
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < `ARD_NUM; i++) begin
                base_r[i] <= `ARD_RST_BASE;
                size_r[i] <= `ARD_RST_SIZE;
            end
        end else begin
            for (int i = 0; i < `ARD_NUM; i++) begin
                base_r[i] <= base_nxt[i];
                size_r[i] <= size_nxt[i];
            end
        end
    end

    // Map is exported straight from the flip-flops
    always_comb begin
        for (int i = 0; i < `ARD_NUM; i++) begin
            mapBase[i*`ARD_AW +: `ARD_AW] = base_r[i];
            mapSize[i*`ARD_AW +: `ARD_AW] = size_r[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbiter

    ard_idx_type grant_r;
    ard_idx_type grant_nxt;
    ard_idx_type master_r;
    ard_idx_type master_nxt;
    logic        mastlock_r;
    logic        mastlock_nxt;
    logic        lockHold;

    // The granted master (grant_r) keeps the bus while it holds its lock
    assign lockHold = hlock[grant_r];

    // Arbitration point is every ready cycle, so ownership hands over
    // without a dead cycle between transfers
    always_comb begin
        grant_nxt    = grant_r;
        master_nxt   = master_r;
        mastlock_nxt = mastlock_r;
        if (hready) begin
            if (lockHold) begin
                grant_nxt = grant_r;
            end else if (|hbusreq) begin
                grant_nxt = rrPick(hbusreq, grant_r);
            end else begin
                grant_nxt = DEF_MASTER;
            end
            master_nxt   = grant_r;
            mastlock_nxt = lockHold;
        end
    end

    // Reset parks the bus on the default master given by parameter DEF_MASTER,
    // so a substituted default owns the bus from the first cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            grant_r    <= DEF_MASTER;
            master_r   <= DEF_MASTER;
            mastlock_r <= 1'b0;
        end else begin
            grant_r    <= grant_nxt;
            master_r   <= master_nxt;
            mastlock_r <= mastlock_nxt;
        end
    end

    assign hgrant    = idxToVec(grant_r);
    assign hmaster   = master_r;
    assign hmastlock = mastlock_r;

    ////////////////////////////////////////////////////////////////////////////
    // Decoder

    ard_vec_type hitVec;
    ard_idx_type selIdx;
    logic        anyHit;
    ard_idx_type dataSel_r;
    ard_idx_type dataSel_nxt;

    // Lowest slave number wins if the host programs overlapping windows
    always_comb begin
        selIdx = DEF_SLAVE;
        anyHit = 1'b0;
        for (int i = 0; i < `ARD_NUM; i++) begin
            hitVec[i] = inRange(haddr, base_r[i], size_r[i]);
        end
        for (int i = `ARD_NUM - 1; i >= 0; i--) begin
            if (hitVec[i]) begin
                selIdx = ard_idx_type'(i);
                anyHit = 1'b1;
            end
        end
    end

    assign hsel = idxToVec(selIdx);

    // Data phase follows the address phase only when the bus moves on
    always_comb begin
        dataSel_nxt = dataSel_r;
        if (hready) begin
            dataSel_nxt = selIdx;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dataSel_r <= DEF_SLAVE;
        end else begin
            dataSel_r <= dataSel_nxt;
        end
    end

    // Response mux is combinational by nature; a register here would
    // cost a wait state on every transfer
    assign hready = hreadyoutS[dataSel_r];
    assign hresp  = hrespS[dataSel_r*`ARD_RESPW +: `ARD_RESPW];
    assign hrdata = hrdataS[dataSel_r*`ARD_DW +: `ARD_DW];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_grant_onehot: assert property ($onehot(hgrant))
        else $error("grant is not one-hot");

    a_rr_rotate: assert property (
        hready && !lockHold && ($countones(hbusreq) > 1)
        |=> hgrant != $past(hgrant))
        else $error("grant did not rotate among several requesters");

    a_grant_requester: assert property (
        hready && !lockHold && (|hbusreq)
        |=> (hgrant & $past(hbusreq)) != `ARD_NO_REQ)
        else $error("grant went to a non-requesting master");

    a_lock_keep: assert property (
        hready && lockHold |=> $stable(hgrant) ##0 hmastlock)
        else $error("locked master lost the bus");

    a_idle_park: assert property (
        hready && !lockHold && (hbusreq == `ARD_NO_REQ)
        |=> hgrant[DEF_MASTER])
        else $error("idle bus not parked on default master");

    a_sel_onehot: assert property ($onehot(hsel))
        else $error("slave select not one-hot");

    a_sel_default: assert property (!anyHit |-> hsel[DEF_SLAVE])
        else $error("unmatched address missed default slave");

    a_steer_pipe: assert property (
        hready |=> hrdata == hrdataS[$past(selIdx)*`ARD_DW +: `ARD_DW])
        else $error("read data not from slave of last address phase");

    a_map_export: assert property (
        cfgWrEn |=> mapBase[$past(cfgIdx)*`ARD_AW +: `ARD_AW] == $past(cfgBase)
                    && mapSize[$past(cfgIdx)*`ARD_AW +: `ARD_AW] == $past(cfgSize))
        else $error("map export does not show written range");

    // Owner and lock flag take the grant of the ready edge, one cycle behind
    a_owner_pipe: assert property (
        hready |=> hmaster == $past(grant_r) && hmastlock == $past(lockHold))
        else $error("owner did not follow grant");

    a_stall_hold: assert property (
        !hready |=> $stable(hmaster) && $stable(dataSel_r)
                    && $stable(hgrant))
        else $error("pipeline moved during wait state");

    a_lock_drop: assert property (
        hready && !lockHold |=> !hmastlock)
        else $error("lock flag stayed after release");

    // Ready and response must come from the same slave as the read data
    a_resp_steer: assert property (
        hready |=> hresp == hrespS[$past(selIdx)*`ARD_RESPW +: `ARD_RESPW]
                   && hready == hreadyoutS[$past(selIdx)])
        else $error("response not from slave of last address phase");

    a_data_default: assert property (
        hready && !anyHit |=> hrdata == hrdataS[DEF_SLAVE*`ARD_DW +: `ARD_DW])
        else $error("unmatched address not answered by default slave");

    // Only the host write port and reset may alter the exported map
    a_map_hold: assert property (
        !cfgWrEn |=> $stable(mapBase) && $stable(mapSize))
        else $error("map changed without a write");

    c_lock_run:  cover property ((hready && lockHold) [*3]);
    c_park:      cover property (hready && hbusreq == `ARD_NO_REQ ##1 hgrant[DEF_MASTER]);
    c_def_slave: cover property (!anyHit ##1 hready);
    c_handover:  cover property (hready && !lockHold ##1 $changed(hgrant) ##1 hready);
    c_stall_end: cover property (!hready ##1 hready);

endmodule

// ==== verification/ard_slave_model.sv ====
`include "ard_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Sixteen AHB slaves, each with its own read data and response
module ard_slave_model
    import ard_pkg::*;
(
    input  wire logic                           stall,
    output logic      [`ARD_NUM-1:0]            hreadyoutS,
    output logic      [`ARD_NUM*`ARD_RESPW-1:0] hrespS,
    output logic      [`ARD_NUM*`ARD_DW-1:0]    hrdataS
);
    timeunit 1ns;
    timeprecision 1ps;

    // Distinct data per slave, so a wrong steer shows at once
    for (genvar i = 0; i < `ARD_NUM; i++) begin : gSlave
        assign hrdataS[i*`ARD_DW +: `ARD_DW]       = 32'h5100_0000 | i;
        assign hrespS[i*`ARD_RESPW +: `ARD_RESPW]  = ard_resp_type'(i & 3);
        assign hreadyoutS[i]                       = ~stall; // Slow answer when stalled
    end
endmodule

// ==== verification/ard_arbiter_decoder_tb.sv ====
`include "ard_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

////////////////////////////////////////////////////////////////////////////////
module ard_arbiter_decoder_tb
    import ard_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {ard_word_type a; ard_vec_type s; int k;} ard_row_type;

    logic         core_clk = 0, reset = 1, stall = 0, cfgWrEn = 0, hmastlock, hready;
    ard_vec_type  hbusreq = '0, hlock = '0, hgrant, hsel, hreadyoutS;
    ard_idx_type  hmaster, cfgIdx = '0;
    ard_word_type haddr = '0, cfgBase = '0, cfgSize = '0, hrdata;
    ard_resp_type hresp;
    logic [`ARD_NUM*`ARD_RESPW-1:0] hrespS;
    logic [`ARD_NUM*`ARD_DW-1:0]    hrdataS, mapBase, mapSize;
    int fail_count = 0, check_count = 0;
    ard_row_type rows[6] = '{'{32'h1000, 16'h0008, 3}, '{32'h10ff, 16'h0008, 3},
        '{32'h1100, 16'h0001, 0}, '{32'h0fff, 16'h0001, 0},
        '{32'h2000, 16'h0020, 5}, '{32'h200f, 16'h0020, 5}};

    ard_arbiter_decoder DUT (.core_clk(core_clk), .reset(reset), .hbusreq(hbusreq),
        .hlock(hlock), .hgrant(hgrant), .hmaster(hmaster), .hmastlock(hmastlock),
        .haddr(haddr), .hsel(hsel), .hreadyoutS(hreadyoutS), .hrespS(hrespS),
        .hrdataS(hrdataS), .hready(hready), .hresp(hresp), .hrdata(hrdata),
        .cfgWrEn(cfgWrEn), .cfgIdx(cfgIdx), .cfgBase(cfgBase), .cfgSize(cfgSize),
        .mapBase(mapBase), .mapSize(mapSize));
    ard_slave_model slaves (.stall(stall), .hreadyoutS(hreadyoutS), .hrespS(hrespS),
        .hrdataS(hrdataS));

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    // Inputs change on the falling edge, away from the sampling edge
    task automatic step();
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // Host programs one slot of the map
    task automatic wr(input ard_idx_type i, input ard_word_type b, input ard_word_type s);
        cfgWrEn = 1; cfgIdx = i; cfgBase = b; cfgSize = s;
        step();
        cfgWrEn = 0; // Strobe drops for a cycle between writes
        step();
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Watchdog: the whole run needs well under 200 cycles
    initial begin
        #20000;
        fail_count++;
        summarize();
    end

    initial begin
        repeat (12) @(negedge core_clk);
        reset = 0;
        `CHK(mapSize, '0)
        `CHK(hsel, 16'h0001)
        wr(3, 32'h1000, 32'h100);
        wr(5, 32'h2000, 32'h10);
        `CHK(mapBase[3*32 +: 32], 32'h1000)
        `CHK(mapSize[5*32 +: 32], 32'h10)
        $display("map test done");
        // Window edges and unmatched addresses: select now, steered data one cycle later
        foreach (rows[n]) begin
            haddr = rows[n].a;
            #1 `CHK(hsel, rows[n].s)
            step();
            `CHK(hrdata, 32'h5100_0000 | rows[n].k)
            `CHK(hresp, rows[n].k[1:0])
        end
        haddr = 32'h3000;
        step();
        $display("decode test done");
        // Back-to-back handover, then park on the default master
        hbusreq = 16'h0006;
        step();
        `CHK({hgrant, hmaster}, {16'h0002, 4'h0})
        step();
        `CHK({hgrant, hmaster}, {16'h0004, 4'h1})
        hbusreq = '0;
        step();
        `CHK({hgrant, hmaster}, {16'h0001, 4'h2})
        $display("rotation test done");
        // Locked owner keeps the bus while others request
        hbusreq = 16'h0006;
        step();
        hlock = 16'h0002;
        repeat (3) step();
        `CHK({hgrant, hmastlock}, {16'h0002, 1'b1})
        hlock = '0;
        step();
        `CHK({hgrant, hmastlock}, {16'h0004, 1'b0})
        $display("lock test done");
        // Wait states freeze arbitration
        stall = 1;
        hbusreq = 16'h0002;
        repeat (2) step();
        `CHK({hready, hgrant}, {1'b0, 16'h0004})
        stall = 0;
        step();
        `CHK(hgrant, 16'h0002)
        // Reset in mid-run clears the map and parks the bus again
        reset = 1;
        #1 `CHK(mapBase, '0)
        step();
        reset = 0;
        haddr = 32'h1000;
        `CHK({hgrant, hmaster, hmastlock}, {16'h0001, 4'h0, 1'b0})
        `CHK(hsel, 16'h0001)
        step();
        `CHK({hgrant, hmaster}, {16'h0002, 4'h0})
        $display("stall and reset test done");
        summarize();
    end
endmodule
